// ===== asp_pkg.sv
package asp_pkg;
   // Clock period in ns
   localparam int CLK_PERIOD_NS = 20;
   // Front-end sample period (1 MHz rate)
   localparam int SAMPLE_PERIOD_NS = 1000;
   localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
   // Fixed pipeline part of the latency
   localparam int FIXED_LAT_NS = 3000;
   localparam int FIXED_LAT_CYCLES = FIXED_LAT_NS / CLK_PERIOD_NS;
   // Start-up time from idle with smallest window
   localparam int STARTUP_US = 35;
   localparam int STARTUP_SAMPLES = STARTUP_US * 1000 / SAMPLE_PERIOD_NS;
   // Angle width and filter window field width
   localparam int ANGLE_W = 16;
   localparam int FW_W = 4;
   // Largest usable filter window shift
   localparam logic [3:0] FW_MAX = 4'hb;
   // Low-power clock tick divider default
   localparam int LP_DIV = 50;
   // Power-mode encodings
   typedef enum logic [1:0] {
      ASP_MODE_IDLE = 2'b00,
      ASP_MODE_ACTIVE = 2'b01,
      ASP_MODE_AUTO = 2'b10
   } asp_mode_t;
endpackage

// ===== asp_tdc.sv
`timescale 1ns/1ns
// Time-to-digital converter: counts from reference edge to zero crossing
module asp_tdc #(
   parameter int W = 16
) (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic run_in,
   input wire logic ref_edge_in,
   input wire logic zero_cross_in,
   output logic [W-1:0] code_out,
   output logic valid_out
);
   logic [W-1:0] count;
   logic [W-1:0] next_count;
   logic [W-1:0] next_code;
   logic next_valid;
   logic armed;
   logic next_armed;

   // Counter restarts at each reference edge, latches on crossing
   always_comb begin
      next_count = count;
      next_code = code_out;
      next_valid = 1'b0;
      next_armed = armed;
      if (!run_in) begin
         // Held idle, powered down
         next_armed = 1'b0;
      end else if (ref_edge_in) begin
         next_count = '0;
         next_armed = 1'b1;
      end else if (armed) begin
         next_count = count + W'(1);
         if (zero_cross_in) begin
            next_code = count;
            next_valid = 1'b1;
            next_armed = 1'b0;
         end
      end
   end

   // State registers
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         count <= '0;
         code_out <= '0;
         valid_out <= 1'b0;
         armed <= 1'b0;
      end else begin
         count <= next_count;
         code_out <= next_code;
         valid_out <= next_valid;
         armed <= next_armed;
      end
   end
endmodule

// ===== asp_core.sv
`timescale 1ns/1ns
// Operation
// - New open-loop angle code at 1 MHz
// - Raw angle from time-to-digital counter
// - First-order low-pass, window sets tau
// - Idle stops front end, output still readable
// - Default direction: clockwise increases angle
// - Configurable direction and zero reference
// - Active mode samples continuously
// - Idle powers down sensing front end
// - Auto mode alternates active and idle
// - Low-power clock times active and cycle
// - Serial reads allowed anytime in auto
// - Auto refresh rate equals cycle time
// - Auto output updates at active end
// - Pins select any of three modes
// - Latency is tau plus 3 us
// - Valid angle 35 us after idle exit
// - Start mode only after chip select high
module asp_core #(
   parameter int LP_DIV = asp_pkg::LP_DIV,
   parameter int ANGLE_W = asp_pkg::ANGLE_W
) (
   input wire logic CLK_IN,
   input wire logic RST_B_IN,
   input wire logic REF_EDGE_IN,
   input wire logic ZERO_CROSS_IN,
   input wire logic CS_B_IN,
   input wire logic PIN_EN_IN,
   input wire logic PIN_AUTO_IN,
   input wire logic PIN_OVERRIDE_IN,
   input wire logic [1:0] CFG_MODE_IN,
   input wire logic [3:0] FILTER_WINDOW_SIZE_IN,
   input wire logic CFG_DIR_CCW_IN,
   input wire logic [15:0] CFG_ZERO_IN,
   input wire logic [7:0] CFG_ACTIVE_TIME_IN,
   input wire logic [7:0] CFG_CYCLE_TIME_IN,
   output logic [15:0] ANGLE_OUT,
   output logic ANGLE_VALID_OUT,
   output logic FRONT_END_ON_OUT,
   output logic [1:0] MODE_OUT
);
   // Elaboration check on parameters
   if (ANGLE_W != 16) begin : g_bad_w
      $error("asp_core supports a 16-bit angle only");
   end
   if (LP_DIV < 1) begin : g_bad_div
      $error("asp_core LP_DIV must be at least 1");
   end

   localparam int LPW = $clog2(LP_DIV + 1);
   localparam int ACC_W = 16 + 12;

   // Start gate, mode and power-cycle state
   logic started;
   logic next_started;
   logic [LPW-1:0] lp_div;
   logic [LPW-1:0] next_lp_div;
   logic lp_tick;
   logic [7:0] cyc_cnt;
   logic [7:0] next_cyc_cnt;
   logic [1:0] next_mode;
   logic fe_on;
   logic next_fe_on;
   logic fe_on_q;
   logic act_end;
   // Filter and output state
   logic [ACC_W-1:0] acc;
   logic [ACC_W-1:0] next_acc;
   logic [15:0] filt;
   logic [15:0] delay_line [asp_pkg::FIXED_LAT_CYCLES];
   logic [15:0] next_angle;
   logic next_valid;
   logic [5:0] warm;
   logic [5:0] next_warm;
   logic [3:0] fw;
   // TDC outputs
   logic [15:0] raw_code;
   logic raw_valid;
   logic [15:0] oriented;

   // Raw angle counter, runs only while front end powered
   // TDC measures phase
   asp_tdc #(.W(16)) u_tdc (
      .clk_in(CLK_IN),
      .rst_b_in(RST_B_IN),
      .run_in(fe_on),
      .ref_edge_in(REF_EDGE_IN),
      .zero_cross_in(ZERO_CROSS_IN),
      .code_out(raw_code),
      .valid_out(raw_valid)
   );

   // Mode selection, start gate and low-power cycle timing
   always_comb begin
      next_started = started;
      next_mode = MODE_OUT;
      next_lp_div = lp_div;
      next_cyc_cnt = cyc_cnt;
      next_fe_on = fe_on;
      lp_tick = 1'b0;
      if (CS_B_IN) begin
         next_started = 1'b1;
      end
      if (PIN_OVERRIDE_IN) begin
         next_mode = PIN_AUTO_IN ? 2'(asp_pkg::ASP_MODE_AUTO)
                   : (PIN_EN_IN ? 2'(asp_pkg::ASP_MODE_ACTIVE) : 2'(asp_pkg::ASP_MODE_IDLE));
      end else if (CFG_MODE_IN != 2'h3) begin
         next_mode = CFG_MODE_IN;
      end
      if (!started) begin
         next_mode = 2'(asp_pkg::ASP_MODE_IDLE);
      end
      // Low-power tick from divider
      if (lp_div == LPW'(LP_DIV - 1)) begin
         next_lp_div = '0;
         lp_tick = 1'b1;
      end else begin
         next_lp_div = lp_div + LPW'(1);
      end
      unique case (MODE_OUT)
         2'(asp_pkg::ASP_MODE_ACTIVE): begin
            next_fe_on = 1'b1;
            next_cyc_cnt = '0;
         end
         2'(asp_pkg::ASP_MODE_AUTO): begin
            if (lp_tick) begin
               if (cyc_cnt + 8'h01 >= CFG_CYCLE_TIME_IN) begin
                  next_cyc_cnt = '0;
               end else begin
                  next_cyc_cnt = cyc_cnt + 8'h01;
               end
            end
            next_fe_on = (next_cyc_cnt < CFG_ACTIVE_TIME_IN);
         end
         default: begin
            next_fe_on = 1'b0;
            next_cyc_cnt = '0;
         end
      endcase
   end

   // End of an active period seen as front end falling
   assign act_end = fe_on_q && !fe_on;

   // Orientation: zero offset then direction
   always_comb begin
      oriented = raw_code - CFG_ZERO_IN;
      if (CFG_DIR_CCW_IN) begin
         oriented = 16'h0000 - oriented;
      end
   end

   // Window clamp
   assign fw = (FILTER_WINDOW_SIZE_IN > asp_pkg::FW_MAX) ? asp_pkg::FW_MAX
             : FILTER_WINDOW_SIZE_IN;
   assign filt = acc[ACC_W-1 -: 16];

   // First-order filter and output update
   always_comb begin
      logic [ACC_W-1:0] diff;
      logic [ACC_W-1:0] samp;
      diff = '0;
      samp = {oriented, 12'h000};
      next_acc = acc;
      next_warm = warm;
      next_angle = ANGLE_OUT;
      next_valid = ANGLE_VALID_OUT;
      // y += (x - y) >> fw
      if (fe_on && raw_valid) begin
         diff = samp - acc;
         next_acc = acc + ACC_W'($signed(diff) >>> fw);
         if (warm < 6'(asp_pkg::STARTUP_SAMPLES)) begin
            next_warm = warm + 6'h01;
         end
      end
      if (!fe_on) begin
         next_warm = '0;
      end
      if (MODE_OUT == 2'(asp_pkg::ASP_MODE_ACTIVE)) begin
         if (warm >= 6'(asp_pkg::STARTUP_SAMPLES)) begin
            next_angle = delay_line[asp_pkg::FIXED_LAT_CYCLES-1];
            next_valid = 1'b1;
         end
      end else if (MODE_OUT == 2'(asp_pkg::ASP_MODE_AUTO) && act_end
                   && warm >= 6'(asp_pkg::STARTUP_SAMPLES)) begin
         // Auto only: leaving active for idle must not refresh the output
         // update at active end
         next_angle = delay_line[asp_pkg::FIXED_LAT_CYCLES-1];
         next_valid = 1'b1;
      end
   end

   // Registers of all groups
   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         started <= 1'b0;
         MODE_OUT <= 2'(asp_pkg::ASP_MODE_IDLE);
         lp_div <= '0;
         cyc_cnt <= '0;
         fe_on <= 1'b0;
         fe_on_q <= 1'b0;
         FRONT_END_ON_OUT <= 1'b0;
         acc <= '0;
         warm <= '0;
         ANGLE_OUT <= '0;
         ANGLE_VALID_OUT <= 1'b0;
         for (int i = 0; i < asp_pkg::FIXED_LAT_CYCLES; i++) begin
            delay_line[i] <= '0;
         end
      end else begin
         started <= next_started;
         MODE_OUT <= next_mode;
         lp_div <= next_lp_div;
         cyc_cnt <= next_cyc_cnt;
         fe_on <= next_fe_on;
         fe_on_q <= fe_on;
         FRONT_END_ON_OUT <= next_fe_on;
         acc <= next_acc;
         warm <= next_warm;
         ANGLE_OUT <= next_angle;
         ANGLE_VALID_OUT <= next_valid;
         // Fixed pipeline delay of the filtered value
         delay_line[0] <= filt;
         for (int i = 1; i < asp_pkg::FIXED_LAT_CYCLES; i++) begin
            delay_line[i] <= delay_line[i-1];
         end
      end
   end
endmodule

// ===== asp_core_assertions.sv
`timescale 1ns/1ns
// Port checks: mode choice, front-end power, angle hold
module asp_chk (
   input wire logic CLK_IN,
   input wire logic RST_B_IN,
   input wire logic CS_B_IN,
   input wire logic PIN_EN_IN,
   input wire logic PIN_AUTO_IN,
   input wire logic PIN_OVERRIDE_IN,
   input wire logic [1:0] CFG_MODE_IN,
   input wire logic [15:0] ANGLE_OUT,
   input wire logic ANGLE_VALID_OUT,
   input wire logic FRONT_END_ON_OUT,
   input wire logic [1:0] MODE_OUT
);
   logic cs_seen; // Select seen high since reset
   wire pin = PIN_OVERRIDE_IN && cs_seen; // Pins govern
   // Sticky flag: mode may only leave idle after it
   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         cs_seen <= 1'b0;
      end else begin
         cs_seen <= cs_seen | CS_B_IN;
      end
   end
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!RST_B_IN);
   // Three settled cycles absorb the pin and mode register stages
   sequence s_idle;
      (MODE_OUT == asp_pkg::ASP_MODE_IDLE) [*3];
   endsequence
   sequence s_act;
      (MODE_OUT == asp_pkg::ASP_MODE_ACTIVE) [*3];
   endsequence
   property p_start;
      MODE_OUT != asp_pkg::ASP_MODE_IDLE |-> cs_seen;
   endproperty
   a_start: assert property (p_start) else $error("mode left idle before select");
   property p_idle_fe;
      s_idle |-> !FRONT_END_ON_OUT;
   endproperty
   a_idle_fe: assert property (p_idle_fe) else $error("front end on in idle");
   property p_act_fe;
      s_act |-> FRONT_END_ON_OUT;
   endproperty
   a_act_fe: assert property (p_act_fe) else $error("front end off in active");
   property p_pin_auto;
      (pin && PIN_AUTO_IN) [*3] |-> MODE_OUT == asp_pkg::ASP_MODE_AUTO;
   endproperty
   a_pin_auto: assert property (p_pin_auto) else $error("auto pin ignored");
   property p_pin_act;
      (pin && PIN_EN_IN && !PIN_AUTO_IN) [*3] |-> MODE_OUT == asp_pkg::ASP_MODE_ACTIVE;
   endproperty
   a_pin_act: assert property (p_pin_act) else $error("enable pin ignored");
   property p_pin_idle;
      (pin && !PIN_EN_IN && !PIN_AUTO_IN) [*3] |-> MODE_OUT == asp_pkg::ASP_MODE_IDLE;
   endproperty
   a_pin_idle: assert property (p_pin_idle) else $error("pins idle ignored");
   property p_reg_act;
      (!PIN_OVERRIDE_IN && cs_seen && CFG_MODE_IN == 2'h1) [*3]
         |-> MODE_OUT == asp_pkg::ASP_MODE_ACTIVE;
   endproperty
   a_reg_act: assert property (p_reg_act) else $error("register mode ignored");
   property p_hold;
      s_idle |-> $stable(ANGLE_OUT);
   endproperty
   a_hold: assert property (p_hold) else $error("angle moved in idle");
   property p_auto_upd;
      MODE_OUT == asp_pkg::ASP_MODE_AUTO && $past(MODE_OUT) == asp_pkg::ASP_MODE_AUTO
         && $changed(ANGLE_OUT) |-> !FRONT_END_ON_OUT;
   endproperty
   a_auto_upd: assert property (p_auto_upd) else $error("auto update mid active");
   property p_valid;
      ANGLE_VALID_OUT |=> ANGLE_VALID_OUT;
   endproperty
   a_valid: assert property (p_valid) else $error("valid flag dropped");
endmodule
bind asp_core asp_chk u_chk (.CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN), .CS_B_IN(CS_B_IN),
   .PIN_EN_IN(PIN_EN_IN), .PIN_AUTO_IN(PIN_AUTO_IN), .PIN_OVERRIDE_IN(PIN_OVERRIDE_IN),
   .CFG_MODE_IN(CFG_MODE_IN), .ANGLE_OUT(ANGLE_OUT), .ANGLE_VALID_OUT(ANGLE_VALID_OUT),
   .FRONT_END_ON_OUT(FRONT_END_ON_OUT), .MODE_OUT(MODE_OUT));

// ===== asp_master.sv
`timescale 1ns/1ns
// Far-side master: chip select and power-mode pins
module asp_master (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic go_in,
   input wire logic [1:0] req_in,
   output logic cs_b_out,
   output logic en_out,
   output logic auto_out
);
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cs_b_out <= 1'b0;
         en_out <= 1'b0;
         auto_out <= 1'b0;
      end else begin
         cs_b_out <= go_in;
         en_out <= req_in[0];
         auto_out <= req_in[1];
      end
   end
endmodule

// ===== testbench.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module testbench;
   logic CLK_IN, RST_B_IN, ref_e, zc, ovr, dir, go, cs_b, en, au, vld, fe;
   logic [1:0] cfg, req, mode;
   logic [3:0] fw;
   logic [15:0] zero, ang, a0, a1;
   logic [7:0] act, cyc, ph, cnt;
   int num_errors = 0, n_compared = 0, tmo = 0, k, hi, lo;
   // 50 MHz clock
   initial begin
      CLK_IN = 1'b0;
      forever #10 CLK_IN = ~CLK_IN;
   end
   // Front end: reference edge each us, crossing ph cycles later
   always @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         cnt <= 8'h00;
         ref_e <= 1'b0;
         zc <= 1'b0;
      end else begin
         cnt <= (cnt == 8'h31) ? 8'h00 : cnt + 8'h01;
         ref_e <= (cnt == 8'h00);
         zc <= (cnt == ph);
      end
   end
   asp_core #(.LP_DIV(50)) u_dut (.CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN), .REF_EDGE_IN(ref_e),
      .ZERO_CROSS_IN(zc), .CS_B_IN(cs_b), .PIN_EN_IN(en), .PIN_AUTO_IN(au),
      .PIN_OVERRIDE_IN(ovr), .CFG_MODE_IN(cfg), .FILTER_WINDOW_SIZE_IN(fw),
      .CFG_DIR_CCW_IN(dir), .CFG_ZERO_IN(zero), .CFG_ACTIVE_TIME_IN(act),
      .CFG_CYCLE_TIME_IN(cyc), .ANGLE_OUT(ang), .ANGLE_VALID_OUT(vld),
      .FRONT_END_ON_OUT(fe), .MODE_OUT(mode));
   asp_master u_mst (.clk_in(CLK_IN), .rst_b_in(RST_B_IN), .go_in(go), .req_in(req),
      .cs_b_out(cs_b), .en_out(en), .auto_out(au));
   // Sample on the falling edge, clear of updates
   task automatic w(input int n);
      repeat (n) @(negedge CLK_IN);
   endtask
   task automatic close_out();
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Hang guard, well beyond the ~14k cycles needed
   always @(posedge CLK_IN) begin
      tmo++;
      if (tmo == 40000) begin
         num_errors++;
         close_out();
      end
   end
   task automatic t_start();
      w(100);
      `CHK("mode", 2'h0, mode)
      `CHK("fe", 1'b0, fe)
      @(posedge CLK_IN);
      go <= 1'b1;
      w(5);
      `CHK("mode", 2'h1, mode)
   endtask
   // Register asks idle, pins must win; auto beats enable
   task automatic t_modes();
      for (int i = 0; i < 4; i++) begin
         @(posedge CLK_IN);
         req <= i[1:0];
         w(5);
         `CHK("pin", (i > 1) ? 2'h2 : i[1:0], mode)
      end
      // Register idle, code 3 keeps it, then register active
      @(posedge CLK_IN);
      ovr <= 1'b0;
      cfg <= 2'h0;
      w(5);
      `CHK("reg", 2'h0, mode)
      @(posedge CLK_IN);
      cfg <= 2'h3;
      w(5);
      `CHK("keep", 2'h0, mode)
      @(posedge CLK_IN);
      cfg <= 2'h1;
      w(5);
      `CHK("reg", 2'h1, mode)
   endtask
   // Window 0 passes raw codes, so relations are exact
   task automatic t_angle();
      k = 0;
      while (vld !== 1'b1 && k < 5000) begin
         w(1);
         k++;
      end
      `CHK("vld", 1'b1, vld)
      w(400);
      a0 = ang;
      @(posedge CLK_IN);
      ph <= 8'h14;
      w(100);
      `CHK("lat", a0, ang)
      w(300);
      `CHK("cw", 1'b1, ang > a0)
      `CHK("tdc", 16'h000a, 16'(ang - a0))
      a1 = ang;
      @(posedge CLK_IN);
      dir <= 1'b1;
      w(400);
      `CHK("ccw", 16'h0, 16'(ang + a1))
      @(posedge CLK_IN);
      dir <= 1'b0;
      zero <= a1;
      w(400);
      `CHK("zero", 16'h0, ang)
      @(posedge CLK_IN);
      zero <= 16'h0;
      w(400);
      // Window 1 halves each step: midway values, then exact
      @(posedge CLK_IN);
      fw <= 4'h1;
      ph <= 8'h0a;
      w(225);
      `CHK("filt", 1'b1, ang > 16'h0009 && ang < 16'h0013)
      w(1000);
      `CHK("settle", 16'h0009, ang)
      @(posedge CLK_IN);
      fw <= 4'h0;
   endtask
   task automatic t_idle();
      @(posedge CLK_IN);
      ovr <= 1'b1;
      req <= 2'h0;
      w(5);
      `CHK("fe", 1'b0, fe)
      a0 = ang;
      @(posedge CLK_IN);
      ph <= 8'h1e;
      w(300);
      `CHK("hold", a0, ang)
      @(posedge CLK_IN);
      req <= 2'h1;
      w(1500);
      `CHK("warm", a0, ang)
      w(600);
      `CHK("wake", 1'b1, ang != a0)
   endtask
   // 40 of 60 ticks active, 50 cycles a tick
   task automatic t_auto();
      a0 = ang;
      @(posedge CLK_IN);
      ovr <= 1'b0;
      cfg <= 2'h2;
      ph <= 8'h28;
      w(2);
      k = 0;
      while (fe && k < 4000) begin
         w(1);
         k++;
      end
      while (!fe && k < 8000) begin
         w(1);
         k++;
      end
      hi = 0;
      while (fe && hi < 4000) begin
         w(1);
         hi++;
      end
      lo = 0;
      while (!fe && lo < 4000) begin
         w(1);
         lo++;
      end
      `CHK("auto", 2'h2, mode)
      `CHK("act", 2000, hi)
      `CHK("per", 3000, hi + lo)
      `CHK("upd", 1'b1, ang != a0)
   endtask
   initial begin
      RST_B_IN = 1'b0;
      {ovr, dir, go} = 3'h4;
      {cfg, req, fw} = 8'h10;
      zero = 16'h0;
      {act, cyc, ph} = 24'h283c0a;
      repeat (20) @(posedge CLK_IN);
      RST_B_IN <= 1'b1;
      t_start();
      t_modes();
      t_angle();
      t_idle();
      t_auto();
      close_out();
   end
endmodule
